// [gpi_pkg.sv]
// Shared constants and types for the pin interrupt and function-select block
package gpi_pkg;

    localparam int unsigned PINS     = 8;
    localparam int unsigned TRIG_PIN = 4;

    // Register byte offsets
    localparam logic [11:0] OFS_SENSE    = 12'h404;
    localparam logic [11:0] OFS_DUAL     = 12'h408;
    localparam logic [11:0] OFS_POL      = 12'h40c;
    localparam logic [11:0] OFS_EN       = 12'h410;
    localparam logic [11:0] OFS_RAW      = 12'h414;
    localparam logic [11:0] OFS_GATED    = 12'h418;
    localparam logic [11:0] OFS_CLR      = 12'h41c;
    localparam logic [11:0] OFS_ALT_FUNCTION_FIELD    = 12'h420;
    localparam logic [11:0] OFS_EVT_STAT = 12'h430;
    localparam logic [11:0] OFS_EVT_MASK = 12'h434;

    // Values after reset
    localparam logic [7:0]  CFG_RST     = 8'h00;
    localparam logic [7:0]  EN_RST      = 8'h00;
    localparam logic [7:0]  RAW_RST     = 8'h00;
    localparam logic [7:0]  ALT_FUNCTION_FIELD_RST_A = 8'h00;
    localparam logic [7:0]  ALT_FUNCTION_FIELD_RST_B = 8'h80;
    localparam logic [7:0]  ALT_FUNCTION_FIELD_RST_C = 8'h0f;
    localparam logic [1:0]  EVT_RST     = 2'h0;
    localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

    // Block event status bit positions
    localparam int unsigned EVT_TRIG   = 0;
    localparam int unsigned EVT_BADACC = 1;

    typedef enum logic [1:0] {
        GPI_PORT_A = 2'h0,
        GPI_PORT_B = 2'h1,
        GPI_PORT_C = 2'h3
    } gpi_port_t;

endpackage

// [gpi_regbus_if.sv]
// Register strobes between the APB slave and the port core
`timescale 1ns/100ps
`default_nettype none
interface gpi_regbus_if;
    logic        wr_stb;
    logic        rd_stb;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] rd_hold;
    logic        addr_ok;

    modport slave (
        output wr_stb, rd_stb, addr, wdata, rd_hold,
        input  rdata, addr_ok
    );
    modport core (
        input  wr_stb, rd_stb, addr, wdata, rd_hold,
        output rdata, addr_ok
    );
endinterface
`default_nettype wire

// [gpi_apb_slave.sv]
// APB slave: one wait-free access phase, read data captured in setup
`timescale 1ns/100ps
`default_nettype none
module gpi_apb_slave
    import gpi_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Core side
    gpi_regbus_if.slave      rb
);
    typedef struct packed {
        logic [31:0] rdata;
    } gpi_apb_st_t;

    gpi_apb_st_t q;
    gpi_apb_st_t d;

    // Capturing in setup keeps prdata a flop without a wait state
    always_comb begin
        d = q;
        if (psel && !penable && !pwrite) begin
            d.rdata = rb.rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{rdata: RDATA_RST};
        end else begin
            q <= d;
        end
    end

    assign rb.wr_stb  = psel && penable && pwrite;
    assign rb.rd_stb  = psel && penable && !pwrite;
    assign rb.addr    = paddr;
    assign rb.wdata   = pwdata;
    assign rb.rd_hold = q.rdata;
    assign prdata     = q.rdata;
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !rb.addr_ok;

    property p_resv_zero;
        @(posedge pclk) disable iff (!presetn)
        rb.rd_stb |-> prdata[31:8] == 24'h00_0000;
    endproperty
    a_resv_zero: assert property (p_resv_zero)
        else $error("reserved read bits not zero");
endmodule
`default_nettype wire

// [gpi_pin_sync.sv]
// Pin synchroniser and edge finder for the eight port pins
`timescale 1ns/100ps
`default_nettype none
module gpi_pin_sync
    import gpi_pkg::*;
(
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // Pins and results
    input  wire logic [PINS-1:0] pin_in,
    output logic      [PINS-1:0] level,
    output logic      [PINS-1:0] rise,
    output logic      [PINS-1:0] fall
);
    typedef struct packed {
        logic [PINS-1:0] meta;
        logic [PINS-1:0] sync;
        logic [PINS-1:0] prev;
    } gpi_sync_st_t;

    gpi_sync_st_t q;
    gpi_sync_st_t d;

    // Only the second and third stages feed the edge logic
    always_comb begin
        d      = q;
        d.meta = pin_in;
        d.sync = q.meta;
        d.prev = q.sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.sync;
    assign rise  = q.sync & ~q.prev;
    assign fall  = ~q.sync & q.prev;
endmodule
`default_nettype wire

// [gpi_port_core.sv]
// Pin interrupt back end and function select of one 8-bit port
`timescale 1ns/100ps
`default_nettype none
module gpi_port_core
    import gpi_pkg::*;
#(
    parameter gpi_port_t PORT_ID = GPI_PORT_B
) (
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Pins and function select
    input  wire logic [PINS-1:0] pin_in,
    output logic      [PINS-1:0] alt_function_sel,
    // Interrupts
    output logic      [PINS-1:0] pin_int,
    output logic                 combined_pin_irq,
    output logic                 block_irq,
    // Converter trigger
    input  wire logic            converter_trigger_select,
    output logic                 conv_ext_trigger,
    output logic                 conv_start
);

    typedef struct packed {
        logic [PINS-1:0] sense;
        logic [PINS-1:0] dual;
        logic [PINS-1:0] pol;
        logic [PINS-1:0] en;
        logic [PINS-1:0] raw;
        logic [PINS-1:0] alt_function_field;
        logic [1:0]      evt;
        logic [1:0]      evt_mask;
        logic            trig;
        logic            start;
    } gpi_core_st_t;

    gpi_core_st_t q;
    gpi_core_st_t d;

    gpi_regbus_if rb ();

    logic [PINS-1:0] level;
    logic [PINS-1:0] rise;
    logic [PINS-1:0] fall;
    logic [PINS-1:0] lvl_hit;
    logic [PINS-1:0] edge_hit;
    logic [PINS-1:0] clr;
    logic [1:0]      evt_set;
    logic [1:0]      evt_rdclr;
    logic            new_hit;
    logic            bad_acc;

    gpi_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .rb      (rb)
    );

    gpi_pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (pin_in),
        .level   (level),
        .rise    (rise),
        .fall    (fall)
    );

    function automatic logic [7:0] alt_function_field_rst(input gpi_port_t p);
        unique case (p)
            GPI_PORT_B: alt_function_field_rst = ALT_FUNCTION_FIELD_RST_B;
            GPI_PORT_C: alt_function_field_rst = ALT_FUNCTION_FIELD_RST_C;
            default:    alt_function_field_rst = ALT_FUNCTION_FIELD_RST_A;
        endcase
    endfunction

    function automatic logic pin_edge(input logic dual, input logic pol,
                                      input logic up, input logic down);
        pin_edge = dual ? (up | down) : (pol ? up : down);
    endfunction

    function automatic logic addr_known(input logic [11:0] a);
        addr_known = (a >= OFS_SENSE && a <= OFS_ALT_FUNCTION_FIELD && a[1:0] == 2'b00)
                  || a == OFS_EVT_STAT || a == OFS_EVT_MASK;
    endfunction

    function automatic logic [31:0] reg_read(input logic [11:0] a,
                                             input gpi_core_st_t s);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            OFS_SENSE:    v = s.sense;
            OFS_DUAL:     v = s.dual;
            OFS_POL:      v = s.pol;
            OFS_EN:       v = s.en;
            OFS_RAW:      v = s.raw;
            OFS_GATED:    v = s.raw & s.en;
            OFS_ALT_FUNCTION_FIELD:    v = s.alt_function_field;
            OFS_EVT_STAT: v = {6'h00, s.evt};
            OFS_EVT_MASK: v = {6'h00, s.evt_mask};
            default:      v = 8'h00;
        endcase
        // Upper bits always read zero
        // reserved bits zero
        reg_read = {24'h00_0000, v};
    endfunction

    // Per-pin detectors
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            assign lvl_hit[gi] = level[gi] == q.pol[gi];
            assign edge_hit[gi] = pin_edge(q.dual[gi], q.pol[gi],
                                           rise[gi], fall[gi]);
        end
    endgenerate

    assign clr = (rb.wr_stb && rb.addr == OFS_CLR) ? rb.wdata[7:0] : 8'h00;

    // A fresh detection on the trigger pin, not a level still held
    assign new_hit = q.sense[TRIG_PIN] ? (lvl_hit[TRIG_PIN] & ~q.raw[TRIG_PIN])
                                       : edge_hit[TRIG_PIN];

    assign bad_acc   = (rb.wr_stb || rb.rd_stb) && !rb.addr_ok;
    assign evt_rdclr = (rb.rd_stb && rb.addr == OFS_EVT_STAT) ? rb.rd_hold[1:0]
                                                              : 2'h0;

    always_comb begin
        d       = q;
        d.trig  = 1'b0;
        d.start = 1'b0;

        // Writes take effect only at the completing access edge
        // upper write bits dropped
        if (rb.wr_stb) begin
            case (rb.addr)
                OFS_SENSE:    d.sense    = rb.wdata[7:0];
                OFS_DUAL:     d.dual     = rb.wdata[7:0];
                OFS_POL:      d.pol      = rb.wdata[7:0];
                OFS_EN:       d.en       = rb.wdata[7:0];
                OFS_ALT_FUNCTION_FIELD:    d.alt_function_field    = rb.wdata[7:0];
                OFS_EVT_MASK: d.evt_mask = rb.wdata[1:0];
                default:      d.evt_mask = q.evt_mask;
            endcase
        end

        // raw ignores enable mask
        // A new edge in the clearing cycle survives: the set wins
        d.raw = (q.sense & lvl_hit) | (~q.sense & ((q.raw & ~clr) | edge_hit));

        if (PORT_ID == GPI_PORT_B) begin
            d.trig = q.en[TRIG_PIN] & new_hit;
        end
        d.start = d.trig & converter_trigger_select;

        // Read clears only the bits that software actually saw
        evt_set = 2'h0;
        evt_set[EVT_TRIG]   = d.trig;
        evt_set[EVT_BADACC] = bad_acc;
        d.evt = (q.evt & ~evt_rdclr) | evt_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.sense    <= CFG_RST;
            q.dual     <= CFG_RST;
            q.pol      <= CFG_RST;
            q.en       <= EN_RST;
            q.raw      <= RAW_RST;
            q.alt_function_field    <= alt_function_field_rst(PORT_ID);
            q.evt      <= EVT_RST;
            q.evt_mask <= EVT_RST;
            q.trig     <= 1'b0;
            q.start    <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign rb.rdata   = reg_read(rb.addr, q);
    assign rb.addr_ok = addr_known(rb.addr);

    assign pin_int          = q.raw & q.en;
    assign combined_pin_irq = |(q.raw & q.en);
    assign alt_function_sel = q.alt_function_field;
    assign conv_ext_trigger = q.trig;
    assign conv_start       = q.start;
    assign block_irq        = |(q.evt & q.evt_mask);

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wr(logic [11:0] a);
        rb.wr_stb && rb.addr == a;
    endsequence

    sequence s_rd(logic [11:0] a);
        rb.rd_stb && rb.addr == a;
    endsequence

    property p_en_write;
        s_wr(OFS_EN) |=> q.en == $past(rb.wdata[7:0]);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("enable write not stored");

    property p_en_block;
        (q.en == 8'h00) |-> !combined_pin_irq && pin_int == 8'h00;
    endproperty
    a_en_block: assert property (p_en_block)
        else $error("masked pin still signals");

    property p_raw_unmasked;
        (~q.sense & edge_hit) != 8'h00 |=>
            (q.raw & $past(~q.sense & edge_hit)) == $past(~q.sense & edge_hit);
    endproperty
    a_raw_unmasked: assert property (p_raw_unmasked)
        else $error("edge not latched in raw status");

    property p_reset_vals;
        $rose(presetn) |-> q.raw == RAW_RST && q.en == EN_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("raw or enable not zero after reset");

    property p_gated_read;
        s_rd(OFS_GATED) |-> rb.rd_hold[7:0] == $past(q.raw & q.en);
    endproperty
    a_gated_read: assert property (p_gated_read)
        else $error("gated status read mismatch");

    property p_clear;
        s_wr(OFS_CLR) |=>
            (q.raw & $past(rb.wdata[7:0] & ~q.sense & ~edge_hit)) == 8'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("edge latch not cleared");

    property p_trig_cause;
        q.trig |-> PORT_ID == GPI_PORT_B && $past(q.en[TRIG_PIN] && new_hit);
    endproperty
    a_trig_cause: assert property (p_trig_cause)
        else $error("trigger without enabled pin 4 event");

    property p_start_sel;
        q.start |-> q.trig && $past(converter_trigger_select);
    endproperty
    a_start_sel: assert property (p_start_sel)
        else $error("start without external select");

    property p_alt_function_field_write;
        s_wr(OFS_ALT_FUNCTION_FIELD) |=> alt_function_sel == $past(rb.wdata[7:0]);
    endproperty
    a_alt_function_field_write: assert property (p_alt_function_field_write)
        else $error("function select not applied");

    property p_alt_function_field_reset;
        $rose(presetn) |-> alt_function_sel == alt_function_field_rst(PORT_ID);
    endproperty
    a_alt_function_field_reset: assert property (p_alt_function_field_reset)
        else $error("function select reset value wrong");

    property p_level_follow;
        1'b1 |=> (q.raw & $past(q.sense)) == $past(q.sense & lvl_hit);
    endproperty
    a_level_follow: assert property (p_level_follow)
        else $error("level mode raw does not follow pin");

    property p_dual;
        1'b1 |-> (edge_hit & q.dual) == (q.dual & (rise | fall));
    endproperty
    a_dual: assert property (p_dual)
        else $error("dual edge not honoured");

    property p_irq_or;
        (q.raw & q.en) != 8'h00 |-> combined_pin_irq ##1 $past(combined_pin_irq);
    endproperty
    a_irq_or: assert property (p_irq_or)
        else $error("combined interrupt missing");

endmodule
`default_nettype wire

// [gpi_far_model.sv]
// Far-side model: port pins and a converter counting trigger pulses
`timescale 1ns/100ps
`default_nettype none
module gpi_far_model
    import gpi_pkg::*;
(
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // Pins
    input  wire logic [PINS-1:0] pin_req,
    output logic      [PINS-1:0] pin_in,
    // Converter
    input  wire logic            conv_ext_trigger,
    input  wire logic            conv_start,
    output logic      [7:0]      trig_count,
    output logic      [7:0]      conv_count
);
    // Pins move once per cycle, like a slow external source
    always @(posedge pclk) begin
        pin_in <= pin_req;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_count <= 8'h00;
            conv_count <= 8'h00;
        end else begin
            trig_count <= trig_count + 8'(conv_ext_trigger);
            conv_count <= conv_count + 8'(conv_start);
        end
    end
endmodule
`default_nettype wire

// [gpio_pin_interrupt_altfunc_tb_top.sv]
// Testbench for the pin interrupt and function-select port
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_interrupt_altfunc_tb_top import gpi_pkg::*;;
    logic            pclk;
    logic            presetn;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [11:0]     paddr;
    logic [31:0]     pwdata;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic [PINS-1:0] pin_req;
    logic [PINS-1:0] pin_in;
    logic [PINS-1:0] alt_function_sel;
    logic [PINS-1:0] pin_int;
    logic            combined_pin_irq;
    logic            block_irq;
    logic            converter_trigger_select;
    logic            conv_ext_trigger;
    logic            conv_start;
    logic [7:0]      trig_count;
    logic [7:0]      conv_count;
    logic [31:0]     rdv;
    logic            errv;
    int              n_fail;
    int              check_count;
    int              cycles;

    gpi_port_core #(.PORT_ID(GPI_PORT_B)) i_gpi_port_core (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .alt_function_sel(alt_function_sel), .pin_int(pin_int),
        .combined_pin_irq(combined_pin_irq), .block_irq(block_irq),
        .converter_trigger_select(converter_trigger_select),
        .conv_ext_trigger(conv_ext_trigger), .conv_start(conv_start)
    );

    gpi_far_model i_gpi_far_model (
        .pclk(pclk), .presetn(presetn), .pin_req(pin_req), .pin_in(pin_in),
        .conv_ext_trigger(conv_ext_trigger), .conv_start(conv_start),
        .trig_count(trig_count), .conv_count(conv_count)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One idle edge first, so a release is never overwritten in its own step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rdv, exp);
    endtask

    // pin_req to raw status takes four edges; six leaves margin
    task automatic pins(input logic [7:0] p);
        @(posedge pclk);
        pin_req <= p;
        repeat (6) @(posedge pclk);
    endtask

    initial begin
        cycles = 0;
        forever begin
            @(posedge pclk);
            cycles++;
            if (cycles == 20000) begin
                n_fail++;
                $display("MISMATCH timeout expected done seen hang");
                finish_test();
            end
        end
    end

    initial begin
        n_fail = 0;
        check_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pin_req = 8'h00;
        converter_trigger_select = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        check("alt_function_field_out", 32'(alt_function_sel), 32'h80);
        rchk("en_rst", OFS_EN, 32'h00);
        check("okerr", 32'(errv), 32'h0);
        rchk("raw_rst", OFS_RAW, 32'h00);
        rchk("gated_rst", OFS_GATED, 32'h00);
        rchk("alt_function_field_rst", OFS_ALT_FUNCTION_FIELD, 32'h80);
        wr(OFS_ALT_FUNCTION_FIELD, 32'hffff_ffda);
        rchk("alt_function_field_rw", OFS_ALT_FUNCTION_FIELD, 32'hda);
        check("alt_function_field_out", 32'(alt_function_sel), 32'hda);
        wr(OFS_ALT_FUNCTION_FIELD, 32'h80);
        // Outputs settle after the access edge
        @(negedge pclk);
        check("alt_function_field_out", 32'(alt_function_sel), 32'h80);
        // Pin 0 rising, pin 1 both edges, pin 2 falling, pin 3 high level, pin 4 rising
        wr(OFS_SENSE, 32'h08);
        wr(OFS_DUAL, 32'h02);
        wr(OFS_POL, 32'h19);
        rchk("sense", OFS_SENSE, 32'h08);
        rchk("dual", OFS_DUAL, 32'h02);
        rchk("pol", OFS_POL, 32'h19);
        pins(8'h04);
        rchk("raw_none", OFS_RAW, 32'h00);
        pins(8'h05);
        rchk("raw_p0", OFS_RAW, 32'h01);
        rchk("gated_off", OFS_GATED, 32'h00);
        check("irq_off", 32'(combined_pin_irq), 32'h0);
        wr(OFS_EN, 32'h01);
        rchk("gated_on", OFS_GATED, 32'h01);
        check("pin_int", 32'(pin_int), 32'h01);
        check("irq_on", 32'(combined_pin_irq), 32'h1);
        wr(OFS_CLR, 32'hfe);
        rchk("clr_zero", OFS_RAW, 32'h01);
        wr(OFS_CLR, 32'h01);
        rchk("clr_one", OFS_RAW, 32'h00);
        check("irq_clr", 32'(combined_pin_irq), 32'h0);
        rchk("clr_read", OFS_CLR, 32'h00);
        pins(8'h07);
        rchk("dual_rise", OFS_RAW, 32'h02);
        wr(OFS_CLR, 32'h02);
        pins(8'h05);
        rchk("dual_fall", OFS_RAW, 32'h02);
        wr(OFS_CLR, 32'h02);
        pins(8'h00);
        rchk("fall_only", OFS_RAW, 32'h04);
        wr(OFS_CLR, 32'h04);
        pins(8'h08);
        rchk("level", OFS_RAW, 32'h08);
        wr(OFS_CLR, 32'h08);
        rchk("level_clr", OFS_RAW, 32'h08);
        pins(8'h00);
        rchk("level_gone", OFS_RAW, 32'h00);
        wr(OFS_EN, 32'h10);
        wr(OFS_EVT_MASK, 32'h01);
        converter_trigger_select <= 1'b1;
        pins(8'h10);
        check("trig", 32'(trig_count), 32'h1);
        check("start", 32'(conv_count), 32'h1);
        check("irq_b4", 32'(combined_pin_irq), 32'h1);
        check("blk_irq", 32'(block_irq), 32'h1);
        rchk("evt", OFS_EVT_STAT, 32'h01);
        @(negedge pclk);
        check("blk_clr", 32'(block_irq), 32'h0);
        wr(OFS_EVT_MASK, 32'h00);
        wr(OFS_CLR, 32'h10);
        converter_trigger_select <= 1'b0;
        pins(8'h00);
        pins(8'h10);
        check("trig2", 32'(trig_count), 32'h2);
        check("nostart", 32'(conv_count), 32'h1);
        check("blk_mask", 32'(block_irq), 32'h0);
        rchk("evt_masked", OFS_EVT_STAT, 32'h01);
        wr(OFS_EVT_MASK, 32'h02);
        apb(1'b0, 12'h42c, 32'h0);
        check("slverr", 32'(errv), 32'h1);
        check("bad_rd", rdv, 32'h0);
        @(negedge pclk);
        check("blk_bad", 32'(block_irq), 32'h1);
        rchk("evt_bad", OFS_EVT_STAT, 32'h02);
        @(negedge pclk);
        check("blk_done", 32'(block_irq), 32'h0);
        wr(OFS_ALT_FUNCTION_FIELD, 32'h00);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("alt_function_field_rerst", 32'(alt_function_sel), 32'h80);
        presetn <= 1'b1;
        rchk("en_rerst", OFS_EN, 32'h00);
        // software hands debug pins back to hardware
        wr(OFS_ALT_FUNCTION_FIELD, 32'h80);
        rchk("alt_function_field_back", OFS_ALT_FUNCTION_FIELD, 32'h80);
        finish_test();
    end
endmodule
`default_nettype wire
